// ---- include/lgoe_pkg.sv ----
package lgoe_pkg;

	// Register indices and the byte addresses that APB uses for them.
	localparam int unsigned APB_ADDR_WIDTH = 12;
	localparam int unsigned APB_DATA_WIDTH = 32;
	localparam logic [APB_ADDR_WIDTH-1:0] IDX_LD_COMPARATOR = 12'h01d;
	localparam logic [APB_ADDR_WIDTH-1:0] IDX_GATE_LOW      = 12'h0fc;
	localparam logic [APB_ADDR_WIDTH-1:0] IDX_GATE_HIGH     = 12'h0fd;
	localparam logic [APB_ADDR_WIDTH-1:0] IDX_GATE_STATUS   = 12'h0fe;
	localparam logic [APB_ADDR_WIDTH-1:0] ADDR_LD_COMPARATOR = IDX_LD_COMPARATOR << 2;
	localparam logic [APB_ADDR_WIDTH-1:0] ADDR_GATE_LOW      = IDX_GATE_LOW << 2;
	localparam logic [APB_ADDR_WIDTH-1:0] ADDR_GATE_HIGH     = IDX_GATE_HIGH << 2;
	localparam logic [APB_ADDR_WIDTH-1:0] ADDR_GATE_STATUS   = IDX_GATE_STATUS << 2;

	// Field positions and widths.
	localparam int unsigned GATE_LOW_WIDTH       = 8;
	localparam int unsigned GATE_HIGH_WIDTH      = 4;
	localparam int unsigned LD_COMPARATOR_BIT    = 3;
	localparam int unsigned STATUS_ENABLE_LSB    = 0;
	localparam int unsigned STATUS_POWERDOWN_LSB = 12;
	localparam int unsigned STATUS_GATING_BIT    = 24;
	localparam int unsigned DEFAULT_OUTPUTS      = 12;

	// Values after reset.
	localparam logic [GATE_LOW_WIDTH-1:0]  GATE_LOW_RESET      = 8'h00;
	localparam logic [GATE_HIGH_WIDTH-1:0] GATE_HIGH_RESET     = 4'h0;
	localparam logic                       LD_COMPARATOR_RESET = 1'b0;
	localparam logic                       CELL_ENABLE_RESET   = 1'b0;
	localparam logic                       CELL_POWERDOWN_RESET = 1'b0;
	localparam logic [APB_DATA_WIDTH-1:0]  READ_DATA_RESET     = 32'h0000_0000;

	// One APB request as the slave sees it in a cycle.
	typedef struct packed {
		logic                      sel;
		logic                      enable;
		logic                      write;
		logic [APB_ADDR_WIDTH-1:0] addr;
		logic [APB_DATA_WIDTH-1:0] wdata;
	} lgoe_apb_req_type;

	// Per-output drive decision.
	typedef struct packed {
		logic enable;
		logic power_down;
	} lgoe_out_state_type;

endpackage

// ---- logic/lgoe_gate_cell.sv ----
`timescale 1ns/10ps
module lgoe_gate_cell
	import lgoe_pkg::*;
(
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// Control.
	input  wire logic         gate_enable_in,
	input  wire logic         lock_gating_signal_in,
	input  wire logic         other_power_down_in,
	// Result.
	output lgoe_out_state_type state_out
);

	logic gated_off;
	logic power_down_next;
	logic enable_next;
	logic power_down_reg;
	logic enable_reg;

	assign gated_off       = gate_enable_in & ~lock_gating_signal_in;
	assign power_down_next = gated_off;
	assign enable_next     = ~gated_off & ~other_power_down_in;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			power_down_reg <= CELL_POWERDOWN_RESET;
			enable_reg     <= CELL_ENABLE_RESET;
		end else begin
			power_down_reg <= power_down_next;
			enable_reg     <= enable_next;
		end
	end

	assign state_out.power_down = power_down_reg;
	assign state_out.enable     = enable_reg;

endmodule // lgoe_gate_cell

// ---- logic/lgoe_top.sv ----
// Notes on behaviour
// - The first gating register holds eight gate enables, bit n for output n, n from 0 to 7.
// - The second gating register holds gate enables for outputs 8 to 11 in bits 3:0, bits 7:4 unused.
// - With its gate enable set and the lock gating signal low, an output is held powered down.
// - With its gate enable set and the lock gating signal high, an output runs unless held off otherwise.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module lgoe_top
	import lgoe_pkg::*;
#(
	parameter int unsigned NUM_OUTPUTS = DEFAULT_OUTPUTS
) (
	// Clock and reset.
	input  wire logic                      clk_in,
	input  wire logic                      rst_b_in,
	// APB slave.
	input  wire logic                      psel_in,
	input  wire logic                      penable_in,
	input  wire logic                      pwrite_in,
	input  wire logic [APB_ADDR_WIDTH-1:0] paddr_in,
	input  wire logic [APB_DATA_WIDTH-1:0] pwdata_in,
	output logic      [APB_DATA_WIDTH-1:0] prdata_out,
	output logic                           pready_out,
	output logic                           pslverr_out,
	// Lock detector and other power-down sources.
	input  wire logic                      lock_detect_in,
	input  wire logic [NUM_OUTPUTS-1:0]    other_power_down_in,
	// Output control.
	output logic                           lock_gating_signal_out,
	output logic      [NUM_OUTPUTS-1:0]    output_enable_out,
	output logic      [NUM_OUTPUTS-1:0]    async_power_down_out
);

	localparam int unsigned HIGH_USED = NUM_OUTPUTS - GATE_LOW_WIDTH;

	// Elaboration checks on the parameter and on the field layout.
	if (NUM_OUTPUTS <= GATE_LOW_WIDTH || HIGH_USED > GATE_HIGH_WIDTH) begin : g_bad
		$error("NUM_OUTPUTS must lie between 9 and 12.");
	end

	if (STATUS_POWERDOWN_LSB < STATUS_ENABLE_LSB + NUM_OUTPUTS) begin : g_bad_status_enable
		$error("The status enable field runs into the power-down field.");
	end

	if (STATUS_GATING_BIT < STATUS_POWERDOWN_LSB + NUM_OUTPUTS ||
		STATUS_GATING_BIT >= APB_DATA_WIDTH) begin : g_bad_status_gating
		$error("The status gating bit does not fit the status word.");
	end

	if (LD_COMPARATOR_BIT >= APB_DATA_WIDTH ||
		GATE_LOW_WIDTH + GATE_HIGH_WIDTH > APB_DATA_WIDTH) begin : g_bad_fields
		$error("A register field does not fit the data bus.");
	end

	if (ADDR_LD_COMPARATOR[1:0] != 2'b00 || ADDR_GATE_LOW[1:0] != 2'b00 ||
		ADDR_GATE_HIGH[1:0] != 2'b00 || ADDR_GATE_STATUS[1:0] != 2'b00) begin : g_bad_align
		$error("Every register address must be word aligned.");
	end

	if (ADDR_GATE_LOW == ADDR_GATE_HIGH || ADDR_GATE_LOW == ADDR_GATE_STATUS ||
		ADDR_GATE_HIGH == ADDR_GATE_STATUS || ADDR_LD_COMPARATOR == ADDR_GATE_LOW) begin : g_bad_map
		$error("Two registers share one address.");
	end

	// Bus request and decode.
	lgoe_apb_req_type                          req;
	logic                                      hit_comparator;
	logic                                      hit_low;
	logic                                      hit_high;
	logic                                      hit_status;
	logic                                      mapped;
	logic                                      setup_phase;
	logic                                      access_phase;
	logic                                      write_strobe;
	logic                                      write_low;
	logic                                      write_high;
	logic                                      write_comparator;

	// Registers and their next values.
	logic [GATE_LOW_WIDTH-1:0]                 gate_low_reg;
	logic [GATE_LOW_WIDTH-1:0]                 gate_low_next;
	logic [GATE_HIGH_WIDTH-1:0]                gate_high_reg;
	logic [GATE_HIGH_WIDTH-1:0]                gate_high_next;
	logic                                      ld_comparator_reg;
	logic                                      ld_comparator_next;
	logic [APB_DATA_WIDTH-1:0]                 prdata_reg;
	logic [APB_DATA_WIDTH-1:0]                 prdata_next;

	// Gating and per-output state.
	logic                                      gating_signal;
	logic [GATE_LOW_WIDTH+GATE_HIGH_WIDTH-1:0] gate_all;
	logic [NUM_OUTPUTS-1:0]                    gate_vec;
	logic [NUM_OUTPUTS-1:0]                    enable_vec;
	logic [NUM_OUTPUTS-1:0]                    power_down_vec;

	// Read words.
	logic [APB_DATA_WIDTH-1:0]                 rd_comparator;
	logic [APB_DATA_WIDTH-1:0]                 rd_low;
	logic [APB_DATA_WIDTH-1:0]                 rd_high;
	logic [APB_DATA_WIDTH-1:0]                 rd_status;
	logic [APB_DATA_WIDTH-1:0]                 read_word;

	// The APB request as the slave sees it this cycle.
	assign req.sel    = psel_in;
	assign req.enable = penable_in;
	assign req.write  = pwrite_in;
	assign req.addr   = paddr_in;
	assign req.wdata  = pwdata_in;

	// Address decode; only aligned words of the four registers are mapped.
	assign hit_comparator = (req.addr == ADDR_LD_COMPARATOR);
	assign hit_low        = (req.addr == ADDR_GATE_LOW);
	assign hit_high       = (req.addr == ADDR_GATE_HIGH);
	assign hit_status     = (req.addr == ADDR_GATE_STATUS);
	assign mapped         = hit_comparator | hit_low | hit_high | hit_status;
	assign setup_phase    = req.sel & ~req.enable;
	assign access_phase   = req.sel & req.enable;
	assign write_strobe   = access_phase & req.write & mapped;

	// Zero wait states; unmapped addresses answer with an error and change nothing.
	assign pready_out  = 1'b1;
	assign pslverr_out = access_phase & ~mapped;

	// One write strobe per register; the status word takes no writes.
	assign write_low        = write_strobe & hit_low;
	assign write_high       = write_strobe & hit_high;
	assign write_comparator = write_strobe & hit_comparator;

	assign gate_low_next = write_low ?
		req.wdata[GATE_LOW_WIDTH-1:0] : gate_low_reg;
	assign gate_high_next = write_high ?
		req.wdata[GATE_HIGH_WIDTH-1:0] : gate_high_reg;
	assign ld_comparator_next = write_comparator ?
		req.wdata[LD_COMPARATOR_BIT] : ld_comparator_reg;

	// The gating signal only exists while the pin comparator is enabled.
	assign gating_signal          = lock_detect_in & ld_comparator_reg;
	assign lock_gating_signal_out = gating_signal;

	// Read data is latched in the setup cycle and held through the access cycle.
	assign rd_comparator = {{(APB_DATA_WIDTH-LD_COMPARATOR_BIT-1){1'b0}},
		ld_comparator_reg, {LD_COMPARATOR_BIT{1'b0}}};
	assign rd_low  = {{(APB_DATA_WIDTH-GATE_LOW_WIDTH){1'b0}}, gate_low_reg};
	assign rd_high = {{(APB_DATA_WIDTH-GATE_HIGH_WIDTH){1'b0}}, gate_high_reg};

	// Status word: output enables, power-downs and the gating signal.
	always_comb begin
		rd_status                                    = READ_DATA_RESET;
		rd_status[STATUS_ENABLE_LSB+:NUM_OUTPUTS]    = enable_vec;
		rd_status[STATUS_POWERDOWN_LSB+:NUM_OUTPUTS] = power_down_vec;
		rd_status[STATUS_GATING_BIT]                 = gating_signal;
	end
	assign read_word = hit_comparator ? rd_comparator :
		hit_low    ? rd_low :
		hit_high   ? rd_high :
		hit_status ? rd_status : READ_DATA_RESET;
	assign prdata_next = setup_phase ? read_word : prdata_reg;

	// Gate enables for outputs 0 to 7.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gate_low_reg <= GATE_LOW_RESET;
		end else begin
			gate_low_reg <= gate_low_next;
		end
	end

	// Gate enables for outputs 8 to 11.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gate_high_reg <= GATE_HIGH_RESET;
		end else begin
			gate_high_reg <= gate_high_next;
		end
	end

	// Lock-detect pin comparator enable.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ld_comparator_reg <= LD_COMPARATOR_RESET;
		end else begin
			ld_comparator_reg <= ld_comparator_next;
		end
	end

	// Read data register.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_reg <= READ_DATA_RESET;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// Read data and the gate enables as one vector.
	assign prdata_out = prdata_reg;
	assign gate_all   = {gate_high_reg, gate_low_reg};
	assign gate_vec   = gate_all[NUM_OUTPUTS-1:0];

	// One gate cell per output.
	for (genvar n = 0; n < NUM_OUTPUTS; n++) begin : g_out
		lgoe_out_state_type state;

		lgoe_gate_cell u_cell (
			.clk_in                (clk_in),
			.rst_b_in              (rst_b_in),
			.gate_enable_in        (gate_vec[n]),
			.lock_gating_signal_in (gating_signal),
			.other_power_down_in   (other_power_down_in[n]),
			.state_out             (state)
		);

		assign enable_vec[n]     = state.enable;
		assign power_down_vec[n] = state.power_down;
	end

	// Drive decisions to the output drivers.
	assign output_enable_out    = enable_vec;
	assign async_power_down_out = power_down_vec;

endmodule // lgoe_top

// ---- tb/lgoe_assertions.sv ----
`timescale 1ns/10ps
module lgoe_assert_chk
	import lgoe_pkg::*;
#(
	parameter int unsigned NUM_OUTPUTS = DEFAULT_OUTPUTS
) (
	// Clock, reset and bus.
	input wire logic                   clk_in,
	input wire logic                   rst_b_in,
	input wire logic                   psel_in,
	input wire logic                   penable_in,
	input wire logic                   pready_out,
	input wire logic                   pslverr_out,
	// Gating.
	input wire logic                   lock_detect_in,
	input wire logic [NUM_OUTPUTS-1:0] other_power_down_in,
	input wire logic                   lock_gating_signal_out,
	input wire logic [NUM_OUTPUTS-1:0] output_enable_out,
	input wire logic [NUM_OUTPUTS-1:0] async_power_down_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_pd_low; |async_power_down_out |-> !$past(lock_gating_signal_out); endproperty
	a_pd_low: assert property (p_pd_low) else $error("power-down with gating high");
	property p_hi_run; $past(lock_gating_signal_out) |-> async_power_down_out == '0; endproperty
	a_hi_run: assert property (p_hi_run) else $error("output held after gating high");
	property p_excl; (output_enable_out & async_power_down_out) == '0; endproperty
	a_excl: assert property (p_excl) else $error("output enabled and powered down");
	property p_other; (output_enable_out & $past(other_power_down_in)) == '0; endproperty
	a_other: assert property (p_other) else $error("output runs while held off");
	property p_rst; $rose(rst_b_in) |-> (async_power_down_out == '0) [*2]; endproperty
	a_rst: assert property (p_rst) else $error("power-down right after reset");
	property p_gate_src; lock_gating_signal_out |-> lock_detect_in; endproperty
	a_gate_src: assert property (p_gate_src) else $error("gating without lock");
	property p_ready; psel_in && penable_in |-> pready_out; endproperty
	a_ready: assert property (p_ready) else $error("access not ready");
	property p_err; pslverr_out |-> psel_in && penable_in; endproperty
	a_err: assert property (p_err) else $error("error outside access cycle");
	c_pd: cover property (|async_power_down_out);
	c_gate: cover property (lock_gating_signal_out ##1 output_enable_out == '1);
	c_err: cover property (pslverr_out);
endmodule // lgoe_assert_chk

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import lgoe_pkg::*;
	logic        clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [11:0] paddr_in = '0, other_power_down_in = '0, exp, en, pd;
	logic [31:0] pwdata_in = '0, prdata_out, r;
	logic        pready_out, pslverr_out, lock_detect_in = 0, gate, e;
	int          bad_count = 0, compares = 0, cycles = 0;
	lgoe_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .lock_detect_in(lock_detect_in),
		.other_power_down_in(other_power_down_in), .lock_gating_signal_out(gate),
		.output_enable_out(en), .async_power_down_out(pd));
	always #4 clk_in = ~clk_in;
	task automatic end_sim;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1;
		penable_in <= 0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		r = prdata_out;
		e = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic settle;
		repeat (2) @(negedge clk_in);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1;
		xfer(0, ADDR_GATE_LOW, 0);
		chk(r, 0);
		xfer(0, ADDR_GATE_HIGH, 0);
		chk(r, 0);
		xfer(0, ADDR_LD_COMPARATOR, 0);
		chk(r, 0);
		@(posedge clk_in);
		lock_detect_in <= 1;
		settle();
		chk(gate, 0);
		@(posedge clk_in);
		lock_detect_in <= 0;
		xfer(1, ADDR_LD_COMPARATOR, 32'h8);
		xfer(0, ADDR_LD_COMPARATOR, 0);
		chk(r, 32'h8);
		for (int n = 0; n < 12; n++) begin
			exp = 12'h1 << n;
			xfer(1, ADDR_GATE_LOW, {24'h0, exp[7:0]});
			xfer(1, ADDR_GATE_HIGH, {28'h0, exp[11:8]});
			settle();
			chk(pd, exp);
			chk(en, {20'h0, ~exp});
		end
		xfer(1, ADDR_GATE_LOW, 32'hff);
		xfer(1, ADDR_GATE_HIGH, 32'hff);
		xfer(0, ADDR_GATE_HIGH, 0);
		chk(r, 32'hf);
		xfer(0, ADDR_GATE_LOW, 0);
		chk(r, 32'hff);
		settle();
		chk(pd, 12'hfff);
		@(posedge clk_in);
		lock_detect_in <= 1;
		settle();
		chk(gate, 1);
		chk(pd, 0);
		chk(en, 12'hfff);
		xfer(0, ADDR_GATE_STATUS, 0);
		chk(r, 32'h0100_0fff);
		@(posedge clk_in);
		other_power_down_in <= 12'h801;
		settle();
		chk(en, 12'h7fe);
		@(posedge clk_in);
		lock_detect_in <= 0;
		other_power_down_in <= 0;
		xfer(1, ADDR_GATE_LOW, 0);
		settle();
		chk(pd, 12'hf00);
		chk(en, 12'h0ff);
		xfer(0, ADDR_GATE_STATUS, 0);
		chk(r, 32'h00f0_00ff);
		xfer(1, 12'h800, 32'h5);
		chk(e, 1);
		xfer(0, 12'h800, 0);
		chk(r, 0);
		@(posedge clk_in);
		lock_detect_in <= 1;
		xfer(1, ADDR_LD_COMPARATOR, 0);
		settle();
		chk(gate, 0);
		chk(pd, 12'hf00);
		@(posedge clk_in);
		rst_b_in <= 0;
		@(posedge clk_in);
		rst_b_in <= 1;
		xfer(0, ADDR_GATE_HIGH, 0);
		chk(r, 0);
		settle();
		chk(pd, 0);
		end_sim();
	end
endmodule // testbench
bind lgoe_top lgoe_assert_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk_u (.clk_in(clk_in),
	.rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .lock_detect_in(lock_detect_in),
	.other_power_down_in(other_power_down_in),
	.lock_gating_signal_out(lock_gating_signal_out),
	.output_enable_out(output_enable_out), .async_power_down_out(async_power_down_out));
